/* mfic_core.v */
`timescale 1ns/10ps
`include "mfic_regs.vh"
// What this block does
// RULE1: ALU saturation mode set by a dedicated one-cycle instruction.
// RULE2: Each core owns an exchange register; select picks whose one is read.
// RULE3: Interrupt config picks resume, restart or ignore for auto return.
// RULE4: Mode bit zero: automatic return when drivers re-enable after disable.
// RULE5: Mode bit one: return when disable flags clear; set clear-on-read.
// RULE6: Backdoor reads and writes to register map, refused when locked.
// RULE7: Program loads backdoor address, and write data, before the transfer.
// RULE8: Read lands in backdoor data; address one cycle, read/write two.
// RULE9: One instruction drives the active-low host interrupt pin directly.
// RULE10: High-side diagnosis mixes drain-source, source-ground and command.
// RULE11: Low-side diagnosis combines only drain-source and command.
// RULE12: Diagnosis enabled for one, all, or via shortcuts, one cycle each.
// RULE13: Enable only on granted outputs; handler starts at diagnosis address.
// RULE14: Calls save the program counter in aux; one nesting level only.
// RULE15: Return from subroutine copies aux plus one into the program counter.
// RULE16: Priority: diagnosis, then driver-disabled, then software interrupt.
// RULE17: Sources: error flags, disable status, software request instruction.
// RULE18: Entry saves PC in interrupt return; queued requests unless flushed.
// RULE19: Interrupt return restores the saved address or the restart address.
// RULE20: Interrupted wait or jump resolved with feedback captured at entry; code does this only for JCR, an interrupted JCRCALL is rerun.
// RULE21: Relative jumps carry 6-bit offset; not taken goes sequentially.
// RULE22: Every relative jump finishes in one cycle, taken or not.
// RULE23: The offset is signed two's complement added to the current counter.
module mfic_core #(
  parameter NCORE = 4,
  parameter CORE  = 0,
  parameter NHS   = 5,
  parameter NLS   = 6,
  parameter PCW   = 10,
  parameter DW    = 16,
  parameter AW    = 10,
  parameter SIDE_B = 0
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             instr_valid,
  input  wire [4:0]       instr_op,
  input  wire [DW-1:0]    instr_arg,
  input  wire             cond_true,
  input  wire [DW-1:0]    xch_peer_in,
  input  wire [DW-1:0]    restart_addr,
  input  wire [DW-1:0]    diag_addr,
  input  wire [DW-1:0]    predriver_setup,
  input  wire [DW-1:0]    clear_on_read_setup,
  input  wire [DW-1:0]    predriver_disable_flags,
  input  wire             drivers_enabled,
  input  wire [DW-1:0]    channel_error_flags,
  input  wire [NHS-1:0]   hs_vds_fbk,
  input  wire [NHS-1:0]   hs_src_fbk,
  input  wire [NHS-1:0]   hs_command,
  input  wire [NLS-1:0]   ls_vds_fbk,
  input  wire [NLS-1:0]   ls_command,
  input  wire [NHS+NLS-1:0] out_granted,
  input  wire [NHS+NLS-1:0] shortcut_mask,
  input  wire [3*NHS-1:0] hs_diag_sel,
  input  wire [2*NLS-1:0] ls_diag_sel,
  input  wire             map_locked,
  input  wire [DW-1:0]    map_rdata,
  output reg  [PCW-1:0]   program_counter_r,
  output reg              sat_en_r,
  output reg  [1:0]       xch_sel_r,
  output reg  [DW-1:0]    core_exchange_register_r,
  output reg  [DW-1:0]    xch_operand_r,
  output reg  [1:0]       ar_mode_r,
  output reg  [AW-1:0]    bd_addr_r,
  output reg  [DW-1:0]    bd_data_r,
  output wire             map_rd_r,
  output wire             map_wr_r,
  output wire [AW-1:0]    map_addr_r,
  output wire             bd_refused_r,
  output reg              host_interrupt_pin_n_r,
  output reg  [NHS+NLS-1:0] diag_en_r,
  output reg              in_irq_r,
  output reg  [2:0]       irq_src_r,
  output reg  [PCW-1:0]   iret_addr_r,
  output reg  [PCW-1:0]   aux_r,
  output reg              stall_r
);
  // ****************************************************
  // Helpers
  // ****************************************************
  localparam NDG = NHS + NLS;
  localparam [PCW-1:0] PC_ONE = {{(PCW-1){1'b0}}, 1'b1};

  function [PCW-1:0] rel_target;
    input [PCW-1:0] pc;
    input [5:0]     ofs;
    begin
      rel_target = pc + {{(PCW-6){ofs[5]}}, ofs}; // see RULE23
    end
  endfunction

  function is_op;
    input       v;
    input [4:0] op;
    input [4:0] want;
    begin
      is_op = v & (op == want);
    end
  endfunction

  // ****************************************************
  // Instruction strobes
  // ****************************************************
  wire [2:0] pend;
  wire       enter = ~in_irq_r & (|pend) & ~stall_r;
  // An instruction met by interrupt entry is dropped and rerun on return, except JCR, which resolves on the feedback captured at entry
  wire exec      = instr_valid & ~stall_r & ~enter;
  wire do_sat    = is_op(exec, instr_op, `MFIC_OP_SETSAT);
  wire do_sel    = is_op(exec, instr_op, `MFIC_OP_SELXCH);
  wire do_iconf  = is_op(exec, instr_op, `MFIC_OP_ICONF);
  wire do_addr   = is_op(exec, instr_op, `MFIC_OP_SETADDR);
  wire do_bdrd   = is_op(exec, instr_op, `MFIC_OP_BDRD);
  wire do_bdwr   = is_op(exec, instr_op, `MFIC_OP_BDWR);
  wire do_irq    = is_op(exec, instr_op, `MFIC_OP_SETIRQ);
  wire do_d1     = is_op(exec, instr_op, `MFIC_OP_DIAG1);
  wire do_dall   = is_op(exec, instr_op, `MFIC_OP_DIAGALL);
  wire do_dsc    = is_op(exec, instr_op, `MFIC_OP_DIAGSC);
  wire do_call   = is_op(exec, instr_op, `MFIC_OP_CALL);
  wire do_rfs    = is_op(exec, instr_op, `MFIC_OP_RFS);
  wire do_reqi   = is_op(exec, instr_op, `MFIC_OP_REQI);
  wire do_iret   = is_op(exec, instr_op, `MFIC_OP_IRET);
  wire do_jcr    = is_op(exec, instr_op, `MFIC_OP_JCR);
  wire do_jcall  = is_op(exec, instr_op, `MFIC_OP_JCRCALL);
  wire do_ldx    = is_op(exec, instr_op, `MFIC_OP_LDXCH);
  wire do_ldd    = is_op(exec, instr_op, `MFIC_OP_LDDATA);

  // ****************************************************
  // Configuration registers
  // ****************************************************
  always @(posedge clk) begin
    if (rst) begin
      sat_en_r  <= 1'b0;
      xch_sel_r <= CORE[1:0];
      ar_mode_r <= `MFIC_AR_RESUME;
      core_exchange_register_r <= {DW{1'b0}};
      xch_operand_r <= {DW{1'b0}};
      host_interrupt_pin_n_r <= 1'b1;
    end else begin
      if (do_sat)
        sat_en_r <= instr_arg[0]; // see RULE1
      if (do_sel)
        xch_sel_r <= instr_arg[1:0]; // see RULE2
      if (do_ldx)
        core_exchange_register_r <= instr_arg;
      // Peer words are muxed outside; this picks own or peer
      xch_operand_r <= (xch_sel_r == CORE[1:0]) ?
                       core_exchange_register_r : xch_peer_in; // see RULE2
      if (do_iconf)
        ar_mode_r <= instr_arg[1:0]; // see RULE3
      if (do_irq)
        host_interrupt_pin_n_r <= instr_arg[0]; // see RULE9
    end
  end

  // ****************************************************
  // Backdoor to the register map
  // ****************************************************
  wire bd_busy;

  mfic_backdoor #(
    .AW (AW),
    .DW (DW)
  ) u_bd (
    .clk        (clk),
    .rst        (rst),
    .start_rd   (do_bdrd | (bd_busy & instr_op == `MFIC_OP_BDRD)),
    .start_wr   (do_bdwr | (bd_busy & instr_op == `MFIC_OP_BDWR)),
    .addr       (bd_addr_r),
    .locked     (map_locked), // see RULE6
    .map_rd_r   (map_rd_r),
    .map_wr_r   (map_wr_r),
    .map_addr_r (map_addr_r),
    .busy_r     (bd_busy),
    .rd_done_r  (),
    .refused_r  (bd_refused_r)
  );

  // Write data is bd_data_r, which the program loads first
  always @(posedge clk) begin
    if (rst) begin
      bd_addr_r <= {AW{1'b0}};
      bd_data_r <= {DW{1'b0}};
    end else begin
      if (do_addr)
        bd_addr_r <= instr_arg[AW-1:0]; // see RULE7
      if (map_rd_r)
        bd_data_r <= map_rdata; // see RULE8
      else if (do_ldd)
        bd_data_r <= instr_arg; // see RULE7
    end
  end

  // ****************************************************
  // Automatic diagnosis
  // ****************************************************
  wire [NDG-1:0] diag_hit;
  genvar h;
  generate
    for (h = 0; h < NHS; h = h + 1) begin : hs
      // Each select bit arms one feedback; fault when any armed one trips
      assign diag_hit[h] = (hs_diag_sel[3*h]   & hs_vds_fbk[h]) |
                           (hs_diag_sel[3*h+1] & hs_src_fbk[h]) |
                           (hs_diag_sel[3*h+2] & hs_command[h]); // see RULE10
    end
    for (h = 0; h < NLS; h = h + 1) begin : ls
      assign diag_hit[NHS+h] =
        (ls_diag_sel[2*h]   & ls_vds_fbk[h]) |
        (ls_diag_sel[2*h+1] & ls_command[h]); // see RULE11
    end
  endgenerate

  wire [NDG-1:0] one_hot_sel = {{(NDG-1){1'b0}}, 1'b1} << instr_arg[3:0];
  reg  [NDG-1:0] diag_en_nxt;
  always @* begin
    diag_en_nxt = diag_en_r;
    if (do_d1)
      diag_en_nxt = (diag_en_r & ~one_hot_sel) |
                    (one_hot_sel & {NDG{instr_arg[4]}} & out_granted);
    else if (do_dall)
      diag_en_nxt = {NDG{instr_arg[4]}} & out_granted; // see RULE12
    else if (do_dsc)
      diag_en_nxt = shortcut_mask & out_granted; // see RULE13
  end

  always @(posedge clk) begin
    if (rst)
      diag_en_r <= {NDG{1'b0}};
    else
      diag_en_r <= diag_en_nxt;
  end

  // ****************************************************
  // Interrupt sources and automatic return
  // ****************************************************
  reg  drv_en_q_r;
  reg  flags_nz_q_r;
  wire flags_nz = |predriver_disable_flags;
  wire mode_bit = predriver_setup[`MFIC_BIT_IRET_MODE];
  wire diag_raise = (|(diag_hit & diag_en_r)) |
                    (|channel_error_flags); // see RULE17
  wire dis_raise  = flags_nz & ~flags_nz_q_r; // see RULE17
  wire auto_ret   = (ar_mode_r != `MFIC_AR_IGNORE) & in_irq_r &
                    (mode_bit ? (flags_nz_q_r & ~flags_nz &
                                 clear_on_read_setup[`MFIC_BIT_DISFLAG_COR])
                              : (drivers_enabled & ~drv_en_q_r));
  // see RULE4 see RULE5

  always @(posedge clk) begin
    if (rst) begin
      drv_en_q_r   <= 1'b1;
      flags_nz_q_r <= 1'b0;
    end else begin
      drv_en_q_r   <= drivers_enabled;
      flags_nz_q_r <= flags_nz;
    end
  end

  wire [2:0] grant;
  wire       leave = (do_iret | auto_ret) & in_irq_r;

  mfic_irq_queue #(
    .NSRC (3)
  ) u_q (
    .clk    (clk),
    .rst    (rst),
    .raise  ({do_reqi, dis_raise, diag_raise}),
    .take   (enter), // see RULE16
    .flush  (do_iret & instr_arg[0]), // see RULE18
    .pend_r (pend),
    .grant  (grant)
  );

  // ****************************************************
  // Program counter and flow control
  // ****************************************************
  reg       call_lvl_r;
  reg       cond_cap_r;
  reg       jmp_irq_r;
  reg [5:0] jmp_ofs_r;
  reg [PCW-1:0] pc_nxt;
  wire jtaken = cond_true & (do_jcr | do_jcall);

  always @* begin
    pc_nxt = program_counter_r;
    if (enter) begin
      if (grant[`MFIC_SRC_DIAG])
        pc_nxt = diag_addr[PCW-1:0]; // see RULE13
      else
        pc_nxt = restart_addr[PCW-1:0];
    end else if (leave) begin
      if (ar_mode_r == `MFIC_AR_RESTART & ~do_iret)
        pc_nxt = restart_addr[PCW-1:0];
      else if (do_iret & instr_arg[1])
        pc_nxt = restart_addr[PCW-1:0]; // see RULE19
      else if (jmp_irq_r)
        pc_nxt = cond_cap_r ? rel_target(iret_addr_r, jmp_ofs_r)
                            : iret_addr_r + PC_ONE; // see RULE20
      else
        pc_nxt = iret_addr_r; // see RULE19
    end else if (do_rfs)
      pc_nxt = aux_r + PC_ONE; // see RULE15
    else if (do_call)
      pc_nxt = instr_arg[PCW-1:0];
    else if (jtaken)
      pc_nxt = rel_target(program_counter_r, instr_arg[5:0]); // see RULE21
    else if (exec & ~((do_bdrd | do_bdwr)))
      pc_nxt = program_counter_r + PC_ONE; // see RULE22
    else if (stall_r)
      pc_nxt = program_counter_r + PC_ONE;
  end

  always @(posedge clk) begin
    if (rst) begin
      program_counter_r <= {PCW{1'b0}};
      aux_r       <= {PCW{1'b0}};
      iret_addr_r <= {PCW{1'b0}};
      in_irq_r    <= 1'b0;
      irq_src_r   <= 3'h0;
      call_lvl_r  <= 1'b0;
      cond_cap_r  <= 1'b0;
      jmp_irq_r   <= 1'b0;
      jmp_ofs_r   <= 6'h00;
      stall_r     <= 1'b0;
    end else begin
      program_counter_r <= pc_nxt;
      // Two-cycle backdoor ops hold the counter for one extra cycle
      stall_r <= do_bdrd | do_bdwr; // see RULE8
      if (enter) begin
        iret_addr_r <= program_counter_r; // see RULE18
        in_irq_r    <= 1'b1;
        irq_src_r   <= grant;
        // Capture the feedback so a pending jump resolves as it stood
        jmp_irq_r   <= instr_valid & (instr_op == `MFIC_OP_JCR);
        cond_cap_r  <= cond_true; // see RULE20
        jmp_ofs_r   <= instr_arg[5:0];
      end else if (leave) begin
        in_irq_r  <= 1'b0;
        irq_src_r <= 3'h0;
        jmp_irq_r <= 1'b0;
      end
      // Single nesting level: a second call overwrites the saved address
      if ((do_call | (do_jcall & cond_true)) & ~enter) begin
        aux_r      <= program_counter_r; // see RULE14
        call_lvl_r <= 1'b1;
      end else if (do_rfs & ~enter)
        call_lvl_r <= 1'b0;
    end
  end
endmodule

/* mfic_regs.vh */
`ifndef MFIC_REGS_VH
`define MFIC_REGS_VH

// ****************************************************
// Register map offsets (host-visible word addresses)
// ****************************************************
`define MFIC_OFS_RESTART0_A    10'h10A
`define MFIC_OFS_RESTART1_A    10'h10B
`define MFIC_OFS_DIAGADDR_A    10'h10C
`define MFIC_OFS_RESTART0_B    10'h12A
`define MFIC_OFS_RESTART1_B    10'h12B
`define MFIC_OFS_DIAGADDR_B    10'h12C
`define MFIC_OFS_PREDRV_SETUP  10'h1C5
`define MFIC_OFS_COR_SETUP     10'h1CE
`define MFIC_OFS_DISABLE_FLAGS 10'h1D2

// ****************************************************
// Field positions
// ****************************************************
`define MFIC_BIT_IRET_MODE     4
`define MFIC_BIT_DISFLAG_COR   2

// ****************************************************
// Instruction opcodes (op field of the decoded word)
// ****************************************************
`define MFIC_OP_NOP     5'h00
`define MFIC_OP_SETSAT  5'h01
`define MFIC_OP_SELXCH  5'h02
`define MFIC_OP_ICONF   5'h03
`define MFIC_OP_SETADDR 5'h04
`define MFIC_OP_BDRD    5'h05
`define MFIC_OP_BDWR    5'h06
`define MFIC_OP_SETIRQ  5'h07
`define MFIC_OP_DIAG1   5'h08
`define MFIC_OP_DIAGALL 5'h09
`define MFIC_OP_DIAGSC  5'h0A
`define MFIC_OP_CALL    5'h0B
`define MFIC_OP_RFS     5'h0C
`define MFIC_OP_REQI    5'h0D
`define MFIC_OP_IRET    5'h0E
`define MFIC_OP_JCR     5'h0F
`define MFIC_OP_JCRCALL 5'h10
`define MFIC_OP_LDXCH   5'h11
`define MFIC_OP_LDDATA  5'h12

// Automatic return modes
`define MFIC_AR_RESUME  2'h0
`define MFIC_AR_RESTART 2'h1
`define MFIC_AR_IGNORE  2'h2

// Interrupt source indices
`define MFIC_SRC_DIAG   0
`define MFIC_SRC_DIS    1
`define MFIC_SRC_SW     2

`endif

/* mfic_backdoor.v */
`timescale 1ns/10ps
// ****************************************************
// Two-cycle backdoor access sequencer
// ****************************************************
module mfic_backdoor #(
  parameter AW = 10,
  parameter DW = 16
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          start_rd,
  input  wire          start_wr,
  input  wire [AW-1:0] addr,
  input  wire          locked,
  output reg           map_rd_r,
  output reg           map_wr_r,
  output reg  [AW-1:0] map_addr_r,
  output reg           busy_r,
  output reg           rd_done_r,
  output reg           refused_r
);
  // Access issued in cycle one, completed in cycle two
  always @(posedge clk) begin
    if (rst) begin
      map_rd_r   <= 1'b0;
      map_wr_r   <= 1'b0;
      map_addr_r <= {AW{1'b0}};
      busy_r     <= 1'b0;
      rd_done_r  <= 1'b0;
      refused_r  <= 1'b0;
    end else begin
      busy_r     <= (start_rd | start_wr) & ~busy_r;
      map_rd_r   <= start_rd & ~busy_r & ~locked;
      map_wr_r   <= start_wr & ~busy_r & ~locked;
      rd_done_r  <= map_rd_r;
      refused_r  <= (start_rd | start_wr) & ~busy_r & locked;
      if ((start_rd | start_wr) & ~busy_r)
        map_addr_r <= addr;
    end
  end
endmodule

/* mfic_irq_queue.v */
`timescale 1ns/10ps
// ****************************************************
// Priority pending queue for three interrupt sources
// ****************************************************
module mfic_irq_queue #(
  parameter NSRC = 3
) (
  input  wire            clk,
  input  wire            rst,
  input  wire [NSRC-1:0] raise,
  input  wire            take,
  input  wire            flush,
  output reg  [NSRC-1:0] pend_r,
  output wire [NSRC-1:0] grant
);
  // Lowest index wins: diagnosis before disable before software
  function [NSRC-1:0] pick;
    input [NSRC-1:0] v;
    integer k;
    begin
      pick = {NSRC{1'b0}};
      for (k = NSRC-1; k >= 0; k = k - 1)
        if (v[k])
          pick = {NSRC{1'b0}} | ({{(NSRC-1){1'b0}}, 1'b1} << k);
    end
  endfunction

  assign grant = pick(pend_r);

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : q
      // A new request beats both the take and the flush
      always @(posedge clk) begin
        if (rst)
          pend_r[g] <= 1'b0;
        else if (raise[g])
          pend_r[g] <= 1'b1;
        else if (flush | (take & grant[g]))
          pend_r[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

/* mfic_core_properties.sv */
`timescale 1ns/10ps
`include "mfic_regs.vh"
module mfic_chk #(
  parameter PCW = 10,
  parameter DW  = 16
) (
  input wire           clk,
  input wire           rst,
  input wire           instr_valid,
  input wire [4:0]     instr_op,
  input wire [DW-1:0]  instr_arg,
  input wire           cond_true,
  input wire           map_locked,
  input wire [DW-1:0]  map_rdata,
  input wire [PCW-1:0] program_counter_r,
  input wire           sat_en_r,
  input wire [DW-1:0]  bd_data_r,
  input wire           map_rd_r,
  input wire           map_wr_r,
  input wire           bd_refused_r,
  input wire           host_interrupt_pin_n_r,
  input wire [PCW-1:0] aux_r,
  input wire           stall_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = instr_valid && !stall_r;

  a_sat_mode: assert property (
    tk && instr_op == `MFIC_OP_SETSAT |=> sat_en_r == $past(instr_arg[0]))
    else $error("saturation mode not taken");
  a_bd_twocycle: assert property (
    tk && (instr_op == `MFIC_OP_BDRD || instr_op == `MFIC_OP_BDWR)
    |=> stall_r ##1 !stall_r) else $error("backdoor not two cycles");
  a_rd_lands: assert property (
    map_rd_r |=> bd_data_r == $past(map_rdata))
    else $error("read data not in backdoor data");
  a_refuse_quiet: assert property (
    bd_refused_r |-> !map_rd_r && !map_wr_r)
    else $error("strobe with refusal");
  a_strobe_unlocked: assert property (
    map_rd_r || map_wr_r |-> !map_locked) else $error("locked access made");
  a_pin_drive: assert property (
    tk && instr_op == `MFIC_OP_SETIRQ
    |=> host_interrupt_pin_n_r == $past(instr_arg[0]))
    else $error("host pin not driven");
  a_jump_taken: assert property (
    tk && instr_op == `MFIC_OP_JCR && cond_true |=> program_counter_r ==
    $past(program_counter_r) + {{(PCW-6){$past(instr_arg[5])}},
    $past(instr_arg[5:0])}) else $error("taken jump target wrong");
  a_jump_seq: assert property (
    tk && instr_op == `MFIC_OP_JCR && !cond_true
    |=> program_counter_r == $past(program_counter_r) + 1'b1)
    else $error("untaken jump not sequential");
  a_call_aux: assert property (
    tk && instr_op == `MFIC_OP_CALL |=> aux_r == $past(program_counter_r))
    else $error("call did not save counter");
  a_rfs_return: assert property (
    tk && instr_op == `MFIC_OP_RFS
    |=> program_counter_r == $past(aux_r) + 1'b1)
    else $error("subroutine return wrong");
endmodule

/* mfic_map_model.sv */
`timescale 1ns/10ps
`include "mfic_regs.vh"
module mfic_map_model #(
  parameter LOCK_ADDR = 10'h1D2
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        map_rd_r,
  input  wire        map_wr_r,
  input  wire [9:0]  map_addr_r,
  input  wire [9:0]  bd_addr_r,
  input  wire [15:0] bd_data_r,
  output wire [15:0] map_rdata,
  output wire        map_locked,
  output wire [15:0] restart_addr,
  output wire [15:0] diag_addr,
  output wire [15:0] predriver_setup,
  output wire [15:0] clear_on_read_setup,
  output wire [15:0] predriver_disable_flags
);
  reg [15:0] mem [0:1023];
  reg [15:0] last_r;
  integer    i;
  assign map_locked = (bd_addr_r == LOCK_ADDR);
  // Idle read bus shows inverted data so a stale value cannot match
  assign map_rdata = map_rd_r ? mem[map_addr_r] : ~last_r;
  assign restart_addr = mem[`MFIC_OFS_RESTART1_A];
  assign diag_addr = mem[`MFIC_OFS_DIAGADDR_A];
  assign predriver_setup = mem[`MFIC_OFS_PREDRV_SETUP];
  assign clear_on_read_setup = mem[`MFIC_OFS_COR_SETUP];
  assign predriver_disable_flags = mem[`MFIC_OFS_DISABLE_FLAGS];
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 1024; i = i + 1)
        mem[i] <= 16'h0000;
      last_r <= 16'h0000;
    end else begin
      if (map_rd_r)
        last_r <= mem[map_addr_r];
      if (map_wr_r && !map_locked)
        mem[map_addr_r] <= bd_data_r;
    end
  end
endmodule

/* mfic_core_test.sv */
`timescale 1ns/10ps
`include "mfic_regs.vh"
module mfic_core_test;
  reg         clk, rst, instr_valid, cond_true, drivers_enabled;
  reg  [4:0]  instr_op;
  reg  [15:0] instr_arg, fbk, err_flags;
  reg  [10:0] granted;
  wire [15:0] rst_addr, dg_addr, setup, cor, dis, rdata, bd_data, xreg, xop;
  wire [9:0]  pc, aux, iret, bd_addr, map_addr;
  wire [10:0] diag_en;
  wire [2:0]  src;
  wire [1:0]  xsel, armode;
  wire        locked, sat, mrd, mwr, refused, pin_n, in_irq, stall;
  integer     n_fail, checks_done, n_ref, i;
  reg  [9:0]  p;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (refused === 1'b1)
      n_ref = n_ref + 1;

  mfic_core #(.CORE(1)) dut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_arg(instr_arg), .cond_true(cond_true), .xch_peer_in(fbk),
    .restart_addr(rst_addr), .diag_addr(dg_addr), .predriver_setup(setup),
    .clear_on_read_setup(cor), .predriver_disable_flags(dis),
    .drivers_enabled(drivers_enabled), .channel_error_flags(err_flags),
    .hs_vds_fbk(fbk[4:0]), .hs_src_fbk(fbk[9:5]), .hs_command(fbk[14:10]),
    .ls_vds_fbk(fbk[5:0]), .ls_command(fbk[11:6]), .out_granted(granted),
    .shortcut_mask(granted), .hs_diag_sel(fbk[14:0]),
    .ls_diag_sel(fbk[11:0]), .map_locked(locked), .map_rdata(rdata),
    .program_counter_r(pc), .sat_en_r(sat), .xch_sel_r(xsel),
    .core_exchange_register_r(xreg), .xch_operand_r(xop), .ar_mode_r(armode),
    .bd_addr_r(bd_addr), .bd_data_r(bd_data), .map_rd_r(mrd),
    .map_wr_r(mwr), .map_addr_r(map_addr), .bd_refused_r(refused),
    .host_interrupt_pin_n_r(pin_n), .diag_en_r(diag_en), .in_irq_r(in_irq),
    .irq_src_r(src), .iret_addr_r(iret), .aux_r(aux), .stall_r(stall));

  mfic_map_model map (
    .clk(clk), .rst(rst), .map_rd_r(mrd), .map_wr_r(mwr),
    .map_addr_r(map_addr), .bd_addr_r(bd_addr), .bd_data_r(bd_data),
    .map_rdata(rdata), .map_locked(locked), .restart_addr(rst_addr),
    .diag_addr(dg_addr), .predriver_setup(setup), .clear_on_read_setup(cor),
    .predriver_disable_flags(dis));

  task chk(input [8*6-1:0] nm, input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task ex(input [4:0] op, input [15:0] a);
    begin
      instr_valid = 1'b1;
      instr_op = op;
      instr_arg = a;
      @(posedge clk);
      #1;
      // Drop the request so the stalled op is not taken a second time
      if (op == `MFIC_OP_BDRD || op == `MFIC_OP_BDWR) begin
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
      end
    end
  endtask
  task wirq;
    integer k;
    begin
      instr_valid = 1'b0;
      k = 0;
      while (in_irq !== 1'b1 && k < 8) begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
    end
  endtask
  task jr(input c, input [5:0] o);
    begin
      p = pc;
      cond_true = c;
      ex(`MFIC_OP_JCR, {10'h000, o});
      chk("jump", pc,
          {6'h00, c ? p + {{4{o[5]}}, o} : p + 10'h001});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_fail = n_fail + 1;
    report_and_stop;
  end

  initial begin
    {rst, instr_valid, cond_true, drivers_enabled} = 4'hF;
    {instr_op, instr_arg, fbk, err_flags, granted} = 0;
    {n_fail, checks_done, n_ref} = 0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk("pc", pc, 16'h0000);
    chk("pin", pin_n, 16'h0001);
    chk("xsel", xsel, 16'h0001);
    $display("test reset done");
    for (i = 0; i < 2; i = i + 1) begin
      ex(`MFIC_OP_SETSAT, 16'h0001 - i);
      chk("sat", sat, 16'h0001 - i);
      ex(`MFIC_OP_SETIRQ, i);
      chk("pin", pin_n, i);
    end
    for (i = 0; i < 4; i = i + 1) begin
      ex(`MFIC_OP_SELXCH, i);
      chk("xsel", xsel, i);
    end
    for (i = 0; i < 3; i = i + 1) begin
      ex(`MFIC_OP_ICONF, i);
      chk("armode", armode, i);
    end
    ex(`MFIC_OP_LDXCH, 16'hA5C3);
    chk("xreg", xreg, 16'hA5C3);
    ex(`MFIC_OP_SELXCH, 16'h0001);
    ex(`MFIC_OP_NOP, 16'h0000);
    chk("xop", xop, 16'hA5C3);
    granted = 11'h7FE;
    ex(`MFIC_OP_DIAG1, 16'h0010);
    chk("dgen", diag_en, 16'h0000);
    granted = 11'h7FF;
    ex(`MFIC_OP_DIAG1, 16'h0010);
    chk("dgen", diag_en, 16'h0001);
    ex(`MFIC_OP_DIAGALL, 16'h0010);
    chk("dgen", diag_en, 16'h07FF);
    $display("test config done");
    ex(`MFIC_OP_SETADDR, `MFIC_OFS_RESTART1_A);
    ex(`MFIC_OP_LDDATA, 16'h0123);
    ex(`MFIC_OP_BDWR, 16'h0000);
    chk("rstadr", rst_addr, 16'h0123);
    ex(`MFIC_OP_LDDATA, 16'hFFFF);
    ex(`MFIC_OP_BDRD, 16'h0000);
    chk("bddata", bd_data, 16'h0123);
    ex(`MFIC_OP_SETADDR, `MFIC_OFS_DISABLE_FLAGS);
    ex(`MFIC_OP_LDDATA, 16'h00AA);
    ex(`MFIC_OP_BDWR, 16'h0000);
    ex(`MFIC_OP_BDRD, 16'h0000);
    chk("bddata", bd_data, 16'h00AA);
    chk("dis", dis, 16'h0000);
    chk("nref", n_ref, 16'h0002);
    $display("test backdoor done");
    jr(1'b1, 6'h05);
    jr(1'b1, 6'h20);
    jr(1'b0, 6'h1F);
    p = pc;
    ex(`MFIC_OP_CALL, 16'h0040);
    chk("aux", aux, p);
    ex(`MFIC_OP_RFS, 16'h0000);
    chk("pc", pc, {6'h00, p + 10'h001});
    p = pc;
    cond_true = 1'b1;
    ex(`MFIC_OP_JCRCALL, 16'h0004);
    chk("aux", aux, p);
    chk("pc", pc, {6'h00, p + 10'h004});
    $display("test flow done");
    p = pc;
    ex(`MFIC_OP_REQI, 16'h0000);
    wirq;
    chk("src", src, 16'h0004);
    chk("iret", iret, p + 10'h001);
    chk("pc", pc, rst_addr[9:0]);
    ex(`MFIC_OP_IRET, 16'h0000);
    chk("pc", pc, p + 10'h001);
    chk("inirq", in_irq, 16'h0000);
    err_flags = 16'h0001;
    ex(`MFIC_OP_REQI, 16'h0000);
    err_flags = 16'h0000;
    wirq;
    chk("src", src, 16'h0001);
    chk("pc", pc, dg_addr[9:0]);
    ex(`MFIC_OP_IRET, 16'h0000);
    wirq;
    chk("src", src, 16'h0004);
    ex(`MFIC_OP_REQI, 16'h0000);
    ex(`MFIC_OP_IRET, 16'h0003);
    chk("pc", pc, rst_addr[9:0]);
    instr_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("inirq", in_irq, 16'h0000);
    ex(`MFIC_OP_ICONF, 16'h0000);
    drivers_enabled = 1'b0;
    ex(`MFIC_OP_REQI, 16'h0000);
    wirq;
    p = iret;
    drivers_enabled = 1'b1;
    @(posedge clk);
    #1;
    chk("inirq", in_irq, 16'h0000);
    chk("pc", pc, p);
    fbk = 16'h0001;
    wirq;
    fbk = 16'h0000;
    chk("src", src, 16'h0001);
    $display("test interrupt done");
    report_and_stop;
  end
endmodule

bind mfic_core mfic_chk #(.PCW(PCW), .DW(DW)) u_chk (
  .clk, .rst, .instr_valid, .instr_op, .instr_arg, .cond_true, .map_locked,
  .map_rdata, .program_counter_r, .sat_en_r, .bd_data_r, .map_rd_r,
  .map_wr_r, .bd_refused_r, .host_interrupt_pin_n_r, .aux_r, .stall_r);
